// ===== fsih_defines.vh
`ifndef FSIH_DEFINES_VH
`define FSIH_DEFINES_VH

// register offsets on the serial control bus
`define FSIH_ADDR_BEST_EFFORT 8'h20
`define FSIH_ADDR_LOCKSTEP 8'h21
`define FSIH_ADDR_FWD_STATE 8'h22
`define FSIH_ADDR_IRQ_CTL 8'h23
`define FSIH_ADDR_IRQ_STS 8'h24

// best-effort forwarding control
`define FSIH_BE_OUT0_BIT 0
`define FSIH_BE_OUT1_BIT 1
`define FSIH_BE_RESET 2'h3

// lockstep mode fields
`define FSIH_LS_OUT0_LSB 2
`define FSIH_LS_OUT1_LSB 4
`define FSIH_LS_RESET 2'h0
`define FSIH_LS_OFF 2'h0
`define FSIH_LS_BASIC 2'h1
`define FSIH_LS_INTERLEAVE 2'h2
`define FSIH_LS_CONCAT 2'h3

// forwarding state flags
`define FSIH_FS_OK_LSB 0
`define FSIH_FS_LOST_LSB 2

// interrupt control and summary
`define FSIH_IRQ_GLOBAL_BIT 7
`define FSIH_IRQ_TX_LSB 4
`define FSIH_IRQ_RX_LSB 0
`define FSIH_IRQ_MASK_RESET 6'h00

`endif

// ===== fsih_sticky.v
`timescale 1ns/1ps
`default_nettype none

module fsih_sticky #(
    parameter W = 1
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // set and clear strobes
    input wire [W-1:0] set,
    input wire [W-1:0] clr,
    // flags
    output wire [W-1:0] flag
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg state;
            // set wins so an event in the clearing cycle is kept
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    state <= 1'b0;
                end else if (set[i]) begin
                    state <= 1'b1;
                end else if (clr[i]) begin
                    state <= 1'b0;
                end
            end
            assign flag[i] = state;
        end
    endgenerate
endmodule // fsih_sticky

`default_nettype wire

// ===== fsih_hub.v
// Overview of operation
// - best-effort enable per output, resets to one
// - lockstep loss flag set after one good frame
// - loss flags clear on read, else stay
// - lockstep ok bit mirrors engine synchronized state
// - lockstep ok reads zero when mode off
// - global enable bit 7 gates interrupt output
// - source masks bits 5..0, reset zero
// - summary bit 7 is OR of masked pendings
// - summary bit ignores the global enable
// - transmitter pending clears on its event read
// - port pending clears on its status reads
// - lockstep mode code: off, basic, interleave, concat
`timescale 1ns/1ps
`default_nettype none
`include "fsih_defines.vh"

module fsih_hub (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // register access from the serial control bus target
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // forwarding engine controls
    output wire out0_best_effort_en,
    output wire out1_best_effort_en,
    output wire [1:0] out0_lockstep_mode,
    output wire [1:0] out1_lockstep_mode,
    // forwarding engine status, index 0 is output port 0
    input wire [1:0] lockstep_active,
    input wire [1:0] lockstep_frame_done,
    input wire [1:0] lockstep_loss,
    // event sources and their clearing reads
    input wire [1:0] tx_event,
    input wire [1:0] tx_event_read,
    input wire [3:0] port_event,
    input wire [3:0] port_event_read,
    // interrupt toward the host controller
    output wire irq_out
);
    reg [1:0] best_effort;
    reg [3:0] lockstep;
    reg global_en;
    reg [5:0] src_mask;
    wire [1:0] armed;
    wire wr_be;
    wire wr_ls;
    wire wr_ctl;
    wire [5:0] masked;
    wire [5:0] pend_set;
    wire [5:0] pend_clr;
    wire [7:0] be_word;
    wire [7:0] ls_word;
    wire [7:0] state_word;
    wire [7:0] ctl_word;
    wire [7:0] sts_word;
    wire [1:0] mode_on;
    wire [1:0] lockstep_ok;
    wire [1:0] lost;
    wire [1:0] lost_set;
    wire [1:0] lost_clr;
    wire [5:0] pending;
    wire summary;
    wire rd_state;
    reg [7:0] next_rdata;

    assign out0_best_effort_en = best_effort[`FSIH_BE_OUT0_BIT];
    assign out1_best_effort_en = best_effort[`FSIH_BE_OUT1_BIT];
    assign out0_lockstep_mode = lockstep[`FSIH_LS_OUT0_LSB-2 +: 2];
    assign out1_lockstep_mode = lockstep[`FSIH_LS_OUT1_LSB-2 +: 2];

    // write strobes, one per writable register
    assign wr_be = reg_wr && (reg_addr == `FSIH_ADDR_BEST_EFFORT);
    assign wr_ls = reg_wr && (reg_addr == `FSIH_ADDR_LOCKSTEP);
    assign wr_ctl = reg_wr && (reg_addr == `FSIH_ADDR_IRQ_CTL);

    // the two modes are not interlocked; software keeps them exclusive
    // best-effort enables come out of reset on
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            best_effort <= `FSIH_BE_RESET;
        end else if (wr_be) begin
            best_effort <= reg_wdata[`FSIH_BE_OUT1_BIT:`FSIH_BE_OUT0_BIT];
        end
    end

    // lockstep mode codes for both outputs
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lockstep <= {`FSIH_LS_RESET, `FSIH_LS_RESET};
        end else if (wr_ls) begin
            lockstep <= reg_wdata[`FSIH_LS_OUT1_LSB+1:`FSIH_LS_OUT0_LSB];
        end
    end

    // global enable kept apart from the masks so the summary never sees it
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            global_en <= 1'b0;
        end else if (wr_ctl) begin
            global_en <= reg_wdata[`FSIH_IRQ_GLOBAL_BIT];
        end
    end

    // per-source masks
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src_mask <= `FSIH_IRQ_MASK_RESET;
        end else if (wr_ctl) begin
            src_mask <= reg_wdata[`FSIH_IRQ_TX_LSB+1:`FSIH_IRQ_RX_LSB];
        end
    end

    // per output port: mode decode, arming, ok bit and loss qualification
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_out
            wire [1:0] mode_sel;
            wire arm_next;
            reg arm_q;
            assign mode_sel = lockstep[2*p +: 2];
            assign mode_on[p] = (mode_sel != `FSIH_LS_OFF);
            // arming drops with the mode, so a re-enable needs a fresh good frame
            assign arm_next = mode_on[p] & (arm_q | lockstep_frame_done[p]);
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    arm_q <= 1'b0;
                end else begin
                    arm_q <= arm_next;
                end
            end
            assign armed[p] = arm_q;
            assign lockstep_ok[p] = mode_on[p] & lockstep_active[p];
            assign lost_set[p] = lockstep_loss[p] & armed[p] & mode_on[p];
        end
    endgenerate

    assign rd_state = reg_rd && (reg_addr == `FSIH_ADDR_FWD_STATE);
    assign lost_clr = {2{rd_state}};

    fsih_sticky #(.W(2)) u_lost (
        .clk(clk),
        .rst_b(rst_b),
        .set(lost_set),
        .clr(lost_clr),
        .flag(lost)
    );

    // pendings clear only from the owning status reads, not the summary
    assign pend_set = {tx_event, port_event};
    assign pend_clr = {tx_event_read, port_event_read};
    fsih_sticky #(.W(6)) u_pending (
        .clk(clk),
        .rst_b(rst_b),
        .set(pend_set),
        .clr(pend_clr),
        .flag(pending)
    );

    // each source counts only through its own mask
    genvar s;
    generate
        for (s = 0; s < 6; s = s + 1) begin : g_src
            assign masked[s] = pending[s] & src_mask[s];
        end
    endgenerate
    assign summary = |masked;
    assign irq_out = global_en & summary;

    // read words, reserved bits tied low
    assign be_word = {6'h00, best_effort};
    assign ls_word = {2'h0, lockstep, 2'h0};
    assign state_word = {4'h0, lost, lockstep_ok};
    assign ctl_word = {global_en, 1'b0, src_mask};
    assign sts_word = {summary, 1'b0, pending};

    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `FSIH_ADDR_BEST_EFFORT: begin
                next_rdata = be_word;
            end
            `FSIH_ADDR_LOCKSTEP: begin
                next_rdata = ls_word;
            end
            `FSIH_ADDR_FWD_STATE: begin
                next_rdata = state_word;
            end
            `FSIH_ADDR_IRQ_CTL: begin
                next_rdata = ctl_word;
            end
            `FSIH_ADDR_IRQ_STS: begin
                next_rdata = sts_word;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // read data is captured in the read cycle, so a clear-on-read shows the old flag
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule // fsih_hub

`default_nettype wire

// ===== fsih_hub_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fsih_hub_sva (
    // clock, reset and register bus
    input wire clk, rst_b, reg_wr, reg_rd,
    input wire [7:0] reg_addr, reg_wdata, reg_rdata,
    // forwarding and interrupt
    input wire out0_best_effort_en, out1_best_effort_en, irq_out,
    input wire [1:0] out0_lockstep_mode, out1_lockstep_mode, lockstep_active, lockstep_loss
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire rd22 = reg_rd && reg_addr == 8'h22;
    wire [1:0] wd_be = reg_wdata[1:0];
    wire [3:0] wd_mode = reg_wdata[5:2];
    // two reads one idle cycle apart with no loss pulse anywhere
    sequence read_gap_read;
        rd22 && !lockstep_loss ##1 !reg_rd && !lockstep_loss ##1 rd22 && !lockstep_loss;
    endsequence
    chk_be_reset: assert property ($rose(rst_b) |-> out0_best_effort_en && out1_best_effort_en)
        else $error("best effort off after reset");
    chk_be_write: assert property (reg_wr && reg_addr == 8'h20 |=>
        {out1_best_effort_en, out0_best_effort_en} == $past(wd_be)) else $error("be write");
    chk_mode_write: assert property (reg_wr && reg_addr == 8'h21 |=>
        {out1_lockstep_mode, out0_lockstep_mode} == $past(wd_mode)) else $error("mode write");
    chk_lost_clear: assert property (read_gap_read |=> reg_rdata[3:2] == 2'h0)
        else $error("loss flag kept after read");
    chk_ok_follows: assert property (rd22 && out0_lockstep_mode != 2'h0 && lockstep_active[0]
        |=> reg_rdata[0]) else $error("ok bit low");
    chk_ok_off: assert property (rd22 && out0_lockstep_mode == 2'h0 |=> !reg_rdata[0])
        else $error("ok bit high with mode off");
    chk_irq_summary: assert property (reg_rd && reg_addr == 8'h24 && irq_out |=> reg_rdata[7])
        else $error("irq without summary");
    chk_ctl_reserved: assert property (reg_rd && reg_addr == 8'h23 |=> !reg_rdata[6])
        else $error("reserved control bit set");
endmodule // fsih_hub_sva
bind fsih_hub fsih_hub_sva u_sva (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_out(irq_out),
    .out0_best_effort_en(out0_best_effort_en), .out1_best_effort_en(out1_best_effort_en),
    .out0_lockstep_mode(out0_lockstep_mode), .out1_lockstep_mode(out1_lockstep_mode),
    .lockstep_active(lockstep_active), .lockstep_loss(lockstep_loss));
`default_nettype wire

// ===== fsih_host.sv
`timescale 1ns/1ps
`default_nettype none
module fsih_host (
    // register bus
    input wire clk,
    input wire [7:0] reg_rdata,
    output logic reg_wr, reg_rd,
    output logic [7:0] reg_addr, reg_wdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    // the #1 lets the taking edge land before the caller looks
    task wr(input [7:0] a, input [7:0] v);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input [7:0] a, output [7:0] v);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
endmodule // fsih_host
`default_nettype wire

// ===== fsih_hub_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fsih_hub_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] act = 2'h0;
    logic [15:0] ev = 16'h0;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, be0, be1, irq;
    logic [1:0] m0, m1;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    fsih_host host (.clk(clk), .reg_rdata(rdata), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata));
    fsih_hub dut (.clk(clk), .rst_b(rst_b), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata), .out0_best_effort_en(be0),
        .out1_best_effort_en(be1), .out0_lockstep_mode(m0), .out1_lockstep_mode(m1),
        .lockstep_active(act), .lockstep_frame_done(ev[1:0]), .lockstep_loss(ev[3:2]),
        .tx_event(ev[5:4]), .tx_event_read(ev[7:6]), .port_event(ev[11:8]),
        .port_event_read(ev[15:12]), .irq_out(irq));
    task end_sim;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task cmp(input [7:0] got, input [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rc(input [7:0] a, input [7:0] exp);
        host.rd(a, d);
        cmp(d, exp);
    endtask
    // event pulses last exactly one taking edge
    task pl(input [15:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 16'h0;
    endtask
    task t_reset;
        cmp({6'h0, be1, be0}, 8'h03);
        rc(8'h20, 8'h03);
        rc(8'h23, 8'h00);
        rc(8'h22, 8'h00);
        rc(8'h30, 8'h00);
        $display("reset test done");
    endtask
    task t_modes;
        host.wr(8'h20, 8'h00);
        for (int m = 0; m < 4; m++) begin
            host.wr(8'h21, 8'(m * 20));
            cmp({2'h0, m1, m0, 2'h0}, 8'(m * 20));
        end
        cmp({6'h0, be1, be0}, 8'h00);
        $display("mode test done");
    endtask
    task t_lock;
        host.wr(8'h21, 8'h14);
        @(posedge clk);
        act <= 2'h1;
        rc(8'h22, 8'h01);
        pl(16'h000C);
        rc(8'h22, 8'h01);
        pl(16'h0003);
        pl(16'h000C);
        rc(8'h22, 8'h0D);
        rc(8'h22, 8'h01);
        host.wr(8'h21, 8'h10);
        rc(8'h22, 8'h00);
        $display("lockstep test done");
    endtask
    task t_irq;
        pl(16'h0F30);
        rc(8'h24, 8'h3F);
        host.wr(8'h23, 8'h3F);
        rc(8'h24, 8'hBF);
        cmp({7'h0, irq}, 8'h00);
        host.wr(8'h23, 8'hBF);
        rc(8'h23, 8'hBF);
        cmp({7'h0, irq}, 8'h01);
        pl(16'h00C0);
        rc(8'h24, 8'h8F);
        rc(8'h24, 8'h8F);
        pl(16'hF000);
        rc(8'h24, 8'h00);
        cmp({7'h0, irq}, 8'h00);
        $display("irq test done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_modes;
        t_lock;
        t_irq;
        end_sim;
    end
    // the whole run needs well under a hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            end_sim;
        end
    end
endmodule // fsih_hub_tb
`default_nettype wire
